// file: kdt_pkg.sv
/*
 * Shared constants and types of the keypad and display transfer unit.
 * Assumes a 100 MHz reference clock and an 80 ns link clock from the computer.
 */
package kdt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// digit register layout
	localparam int DIGITS = 9;
	localparam int DIG_W = 4;
	localparam int REG_W = 36;
	localparam int ADDR_DIGITS = 3;
	localparam int DATA_DIGITS = 5;
	localparam int SIGN_IDX = 3;
	localparam int DATA_BASE = 4;
	localparam int SEG_W = 7;

	localparam logic [3:0] CODE_BLANK = 4'hF;
	localparam logic [3:0] CODE_PLUS = 4'hA;
	localparam logic [3:0] CODE_MINUS = 4'hB;
	localparam logic [3:0] MAX_ADDR_CODE = 4'h7;
	localparam logic [3:0] CNT_COMMIT = 4'h9;
	localparam logic [3:0] CNT_READOUT = 4'h3;
	localparam logic [3:0] CNT_SIGN = 4'h3;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [REG_W-1:0] REG_BLANK = 36'hF_FFFF_FFFF;

	// segment order g f e d c b a, one bit lit
	localparam logic [0:9][SEG_W-1:0] SEG_TABLE = {
		7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
		7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F
	};
	localparam logic [SEG_W-1:0] SEG_DARK = 7'h00;

	////////////////////////////////////////////////////////////////////////////
	// keys
	localparam int KEY_N = 5;
	localparam int KEY_DIGIT = 0;
	localparam int KEY_WIPE = 1;
	localparam int KEY_COMMIT = 2;
	localparam int KEY_READOUT = 3;
	localparam int KEY_FREEZE = 4;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int REF_CLK_MHZ = 100;
	localparam int DEBOUNCE_US = 5000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * REF_CLK_MHZ;
	localparam int DB_CNT_W = 20;
	localparam int LINK_PERIOD_NS = 80;
	localparam int DATA_PULSE_NS = 2000;
	localparam int PULSE_W = 5;
	localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(DATA_PULSE_NS / LINK_PERIOD_NS - 1);
	localparam logic [1:0] LAST_BIT = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// link sequencer
	localparam logic DIR_UP = 1'b0;
	localparam logic DIR_DOWN = 1'b1;

	typedef enum logic [1:0] {
		LS_IDLE = 2'b00,
		LS_WAIT = 2'b01,
		LS_DATA = 2'b10,
		LS_SHIFT = 2'b11
	} kdt_link_st_t;

endpackage : kdt_pkg

// file: kdt_key_debounce.sv
/*
 * One key line: two-stage synchroniser, debounce, one-cycle press strobe.
 * Assumes a raw, bouncing, active-high key level from the panel.
 */
module kdt_key_debounce
	import kdt_pkg::*;
#(
	parameter int P_CYC = DEBOUNCE_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_key,
	output logic o_strobe
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic stable;
		logic [DB_CNT_W-1:0] cnt;
		logic strobe;
	} kdt_db_t;

	kdt_db_t st_r;
	kdt_db_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = i_key;
		st_nxt.s2 = st_r.s1;
		st_nxt.strobe = 1'b0;
		if (st_r.s2 != st_r.stable) begin
			st_nxt.cnt = st_r.cnt + DB_CNT_W'(1);
			if (st_r.cnt == DB_CNT_W'(P_CYC - 1)) begin
				st_nxt.cnt = '0;
				st_nxt.stable = st_r.s2;
				st_nxt.strobe = st_r.s2; // [RL24]
			end
		end else begin
			st_nxt.cnt = '0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_strobe = st_r.strobe;

endmodule : kdt_key_debounce

// file: kdt_digit_decode.sv
/*
 * One numeric display digit: 4-bit code to registered segment drives.
 * Assumes the code comes from logic on the same clock.
 */
module kdt_digit_decode
	import kdt_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [DIG_W-1:0] i_code,
	input wire logic i_lit,
	output logic [SEG_W-1:0] o_seg
);

	typedef struct packed {
		logic [SEG_W-1:0] seg;
	} kdt_dec_t;

	kdt_dec_t st_r;
	kdt_dec_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		// blank code and non-decimal codes leave the digit dark
		if (!i_lit || i_code > 4'h9) begin // [RL1] [RL19]
			st_nxt.seg = SEG_DARK;
		end else begin
			st_nxt.seg = SEG_TABLE[i_code]; // [RL15]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_seg = st_r.seg;

endmodule : kdt_digit_decode

// file: kdt_transfer_unit.sv
/*
 * Keypad and numeric display transfer unit: key entry into a nine-digit
 * register, display decode, and nibble-wise serial trade with the computer.
 * Assumes keys and logic power arrive as raw pins, and that the computer
 * runs the link clock while it requests and answers transfers.
 */
// What this block and the computer do
// RL1: numerics dark without logic power
// RL2: wipe key starts entry, enables digit keys
// RL3: digits fill register from most significant
// RL4: commit without nine digits flags error
// RL5: display request without three flags error
// RL6: computer answers key signal with upload
// RL7: upload: four data/shift pulse pairs
// RL8: computer uploads until all digits sent
// RL9: download: four shifts, capture four bits
// RL10: computer downloads until word complete
// RL11: word held until update or wipe
// RL12: computer stops downloads after freeze
// RL13: display request resumes frozen downloads
// RL14: computer serves only 512 addresses
// RL15: own decoder per digit, segment outputs
// RL16: positions one to three form address
// RL17: position four gives plus or minus
// RL18: positions five to nine form data
// RL19: all-ones code blanks the digit
// RL20: register is nine 4-bit digits
// RL21: error forces uploaded bits to one
// RL22: upload data bit gated by 2 us pulse
// RL23: ones shift in behind uploaded digits
// RL24: keys synchronised, debounced to strobes
module kdt_transfer_unit
	import kdt_pkg::*;
#(
	parameter int P_DEBOUNCE_CYC = DEBOUNCE_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_link_clk,
	input wire logic [KEY_N-1:0] i_key_pin,
	input wire logic [DIG_W-1:0] i_key_code,
	input wire logic i_logic_pwr,
	input wire logic i_upload_req,
	input wire logic i_download_req,
	input wire logic i_link_data,
	output logic o_link_data,
	output logic o_link_shift,
	output logic o_commit_lvl,
	output logic o_readout_lvl,
	output logic o_freeze_lvl,
	output logic o_op_error,
	output logic o_sign_plus,
	output logic o_sign_minus,
	output logic [ADDR_DIGITS-1:0][SEG_W-1:0] o_addr_glow_numeric_display,
	output logic [DATA_DIGITS-1:0][SEG_W-1:0] o_data_glow_numeric_display
);

	////////////////////////////////////////////////////////////////////////////
	// state of the reference-clock side
	typedef struct packed {
		logic [REG_W-1:0] dreg;
		logic [3:0] cnt;
		logic entry_en;
		logic err;
		logic commit_lvl;
		logic readout_lvl;
		logic freeze_lvl;
		logic [DIG_W-1:0] code_s1;
		logic [DIG_W-1:0] code_s2;
		logic pwr_s1;
		logic pwr_s2;
		logic req_s1;
		logic req_s2;
		logic req_q;
		logic done_s1;
		logic done_s2;
		logic done_q;
		logic ack_t;
		logic [DIG_W-1:0] up_nib;
		logic sign_p;
		logic sign_m;
	} kdt_sys_t;

	// state of the link-clock side
	typedef struct packed {
		kdt_link_st_t st;
		logic [1:0] bit_cnt;
		logic [PULSE_W-1:0] wid;
		logic dir;
		logic req_t;
		logic ack_s1;
		logic ack_s2;
		logic ack_q;
		logic [DIG_W-1:0] in_nib;
		logic done_t;
		logic data_o;
		logic shift_o;
	} kdt_lnk_t;

	kdt_sys_t s_r;
	kdt_sys_t s_nxt;
	kdt_lnk_t l_r;
	kdt_lnk_t l_nxt;

	logic [KEY_N-1:0] key_stb;
	logic code_is_sign;
	logic up_bit;

	////////////////////////////////////////////////////////////////////////////
	// key conditioning

	genvar gk;
	generate
		for (gk = 0; gk < KEY_N; gk++) begin : g_key
			kdt_key_debounce #(
				.P_CYC(P_DEBOUNCE_CYC)
			) u_db (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_key(i_key_pin[gk]),
				.o_strobe(key_stb[gk])
			);
		end
	endgenerate

	// the code lines settle long before the debounced strobe
	assign code_is_sign = (s_r.code_s2 == CODE_PLUS) || (s_r.code_s2 == CODE_MINUS);

	////////////////////////////////////////////////////////////////////////////
	// entry, register and transfer handshake, reference clock

	always_comb begin
		s_nxt = s_r;
		s_nxt.code_s1 = i_key_code;
		s_nxt.code_s2 = s_r.code_s1;
		s_nxt.pwr_s1 = i_logic_pwr;
		s_nxt.pwr_s2 = s_r.pwr_s1;
		s_nxt.req_s1 = l_r.req_t;
		s_nxt.req_s2 = s_r.req_s1;
		s_nxt.req_q = s_r.req_s2;
		s_nxt.done_s1 = l_r.done_t;
		s_nxt.done_s2 = s_r.done_s1;
		s_nxt.done_q = s_r.done_s2;

		if (key_stb[KEY_WIPE]) begin
			// wipe blanks the word and ends any display operation
			s_nxt.dreg = REG_BLANK; // [RL2] [RL11]
			s_nxt.cnt = '0;
			s_nxt.err = 1'b0;
			s_nxt.entry_en = 1'b1; // [RL2]
			s_nxt.commit_lvl = 1'b0;
			s_nxt.readout_lvl = 1'b0;
			s_nxt.freeze_lvl = 1'b0;
		end else if (key_stb[KEY_DIGIT] && s_r.entry_en) begin
			if (s_r.cnt == CNT_COMMIT) begin
				s_nxt.err = 1'b1;
			end else begin
				for (int i = 0; i < DIGITS; i++) begin
					if (s_r.cnt == 4'(i)) begin
						s_nxt.dreg[REG_W-1-i*DIG_W -: DIG_W] = s_r.code_s2; // [RL3] [RL20]
					end
				end
				s_nxt.cnt = s_r.cnt + CNT_ONE;
				// sign only in the fourth place; no 8 or 9 in the address
				if ((s_r.cnt == CNT_SIGN) != code_is_sign) begin
					s_nxt.err = 1'b1;
				end
				if (s_r.cnt < CNT_SIGN && s_r.code_s2 > MAX_ADDR_CODE) begin
					s_nxt.err = 1'b1;
				end
			end
		end else if (key_stb[KEY_COMMIT] && s_r.entry_en) begin
			s_nxt.entry_en = 1'b0;
			s_nxt.commit_lvl = 1'b1;
			if (s_r.cnt != CNT_COMMIT) begin
				s_nxt.err = 1'b1; // [RL4]
			end
		end else if (key_stb[KEY_READOUT]) begin
			// a second press after freezing asks for updates again
			s_nxt.readout_lvl = 1'b1;
			s_nxt.freeze_lvl = 1'b0;
			if (s_r.entry_en) begin
				s_nxt.entry_en = 1'b0;
				if (s_r.cnt != CNT_READOUT) begin
					s_nxt.err = 1'b1; // [RL5]
				end
			end
		end else if (key_stb[KEY_FREEZE] && s_r.readout_lvl) begin
			s_nxt.freeze_lvl = 1'b1;
		end

		// upload step: hand the top digit across, ones fill behind
		if (s_r.req_s2 != s_r.req_q) begin
			if (s_r.entry_en) begin
				s_nxt.err = 1'b1;
			end
			if (l_r.dir == DIR_UP) begin
				if (s_nxt.err) begin
					s_nxt.up_nib = CODE_BLANK; // [RL21]
				end else begin
					s_nxt.up_nib = s_nxt.dreg[REG_W-1 -: DIG_W]; // [RL7]
				end
				s_nxt.dreg = {s_nxt.dreg[REG_W-DIG_W-1:0], CODE_BLANK}; // [RL23]
			end
			s_nxt.ack_t = ~s_r.ack_t;
		end

		// download step: the new nibble enters at the least significant end
		if (s_r.done_s2 != s_r.done_q) begin
			s_nxt.dreg = {s_nxt.dreg[REG_W-DIG_W-1:0], l_r.in_nib}; // [RL9] [RL11]
		end

		s_nxt.sign_p = s_r.pwr_s2 && (s_r.dreg[REG_W-1-SIGN_IDX*DIG_W -: DIG_W] == CODE_PLUS); // [RL17] [RL1]
		s_nxt.sign_m = s_r.pwr_s2 && (s_r.dreg[REG_W-1-SIGN_IDX*DIG_W -: DIG_W] == CODE_MINUS); // [RL17] [RL1]
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
			s_r.dreg <= REG_BLANK;
			s_r.up_nib <= CODE_BLANK;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial sequencer, link clock

	// up_nib only changes in the same cycle as the ack toggle that lets it be read here
	assign up_bit = s_r.up_nib[LAST_BIT - l_r.bit_cnt];

	always_comb begin
		l_nxt = l_r;
		l_nxt.ack_s1 = s_r.ack_t;
		l_nxt.ack_s2 = l_r.ack_s1;
		case (l_r.st)
			LS_IDLE: begin
				l_nxt.data_o = 1'b0;
				l_nxt.shift_o = 1'b0;
				if (i_upload_req || i_download_req) begin
					// upload wins if both arrive together
					l_nxt.dir = i_upload_req ? DIR_UP : DIR_DOWN;
					l_nxt.req_t = ~l_r.req_t;
					l_nxt.st = LS_WAIT;
				end
			end
			LS_WAIT: begin
				if (l_r.ack_s2 != l_r.ack_q) begin
					l_nxt.ack_q = l_r.ack_s2;
					l_nxt.bit_cnt = '0;
					l_nxt.wid = '0;
					l_nxt.st = (l_r.dir == DIR_UP) ? LS_DATA : LS_SHIFT;
					l_nxt.shift_o = (l_r.dir == DIR_DOWN);
					// data rises with the state, else the pulse is one cycle short
					l_nxt.data_o = (l_r.dir == DIR_UP) && s_r.up_nib[LAST_BIT]; // [RL22]
				end
			end
			LS_DATA: begin
				// data step; on download it is only the gap between shifts
				l_nxt.data_o = (l_r.dir == DIR_UP) && up_bit; // [RL22]
				l_nxt.wid = l_r.wid + PULSE_W'(1);
				if (l_r.wid == PULSE_LAST) begin
					l_nxt.data_o = 1'b0;
					l_nxt.shift_o = 1'b1; // [RL7] [RL9]
					l_nxt.wid = '0;
					l_nxt.st = LS_SHIFT;
				end
			end
			LS_SHIFT: begin
				l_nxt.wid = l_r.wid + PULSE_W'(1);
				if (l_r.wid == PULSE_LAST) begin
					l_nxt.shift_o = 1'b0;
					l_nxt.wid = '0;
					if (l_r.dir == DIR_DOWN) begin
						l_nxt.in_nib = {l_r.in_nib[DIG_W-2:0], i_link_data}; // [RL9]
					end
					if (l_r.bit_cnt == LAST_BIT) begin
						if (l_r.dir == DIR_DOWN) begin
							l_nxt.done_t = ~l_r.done_t;
						end
						l_nxt.st = LS_IDLE;
					end else begin
						l_nxt.bit_cnt = l_r.bit_cnt + 2'h1;
						l_nxt.st = LS_DATA;
						l_nxt.data_o = (l_r.dir == DIR_UP) && s_r.up_nib[LAST_BIT - l_nxt.bit_cnt]; // [RL22]
					end
				end
			end
			default: begin
				l_nxt.st = LS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display decode

	genvar ga;
	generate
		for (ga = 0; ga < ADDR_DIGITS; ga++) begin : g_addr
			kdt_digit_decode u_dec (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_code(s_r.dreg[REG_W-1-ga*DIG_W -: DIG_W]), // [RL16]
				.i_lit(s_r.pwr_s2),
				.o_seg(o_addr_glow_numeric_display[ga])
			);
		end
		for (ga = 0; ga < DATA_DIGITS; ga++) begin : g_data
			kdt_digit_decode u_dec (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_code(s_r.dreg[REG_W-1-(DATA_BASE+ga)*DIG_W -: DIG_W]), // [RL18]
				.i_lit(s_r.pwr_s2),
				.o_seg(o_data_glow_numeric_display[ga])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_link_data = l_r.data_o;
	assign o_link_shift = l_r.shift_o;
	// the computer watches these levels and then issues requests
	assign o_commit_lvl = s_r.commit_lvl; // [RL6]
	assign o_readout_lvl = s_r.readout_lvl; // [RL13]
	assign o_freeze_lvl = s_r.freeze_lvl; // [RL12]
	assign o_op_error = s_r.err;
	assign o_sign_plus = s_r.sign_p;
	assign o_sign_minus = s_r.sign_m;

endmodule : kdt_transfer_unit

// file: kdt_transfer_unit_asserts.sv
/* Port checker of the transfer unit, bound into every instance.
   Assumes the debounce parameter is passed on by the bind. */
module kdt_transfer_unit_chk
	import kdt_pkg::*;
#(
	parameter int P_DEBOUNCE_CYC = DEBOUNCE_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_link_clk,
	input wire logic [KEY_N-1:0] i_key_pin,
	input wire logic i_logic_pwr,
	input wire logic o_link_data,
	input wire logic o_link_shift,
	input wire logic o_commit_lvl,
	input wire logic o_readout_lvl,
	input wire logic o_op_error,
	input wire logic o_sign_plus,
	input wire logic o_sign_minus,
	input wire logic [ADDR_DIGITS-1:0][SEG_W-1:0] o_addr_glow_numeric_display,
	input wire logic [DATA_DIGITS-1:0][SEG_W-1:0] o_data_glow_numeric_display
);
	logic [2:0] off_r;
	int wipe_r;
	logic [5:0] sh_r;
	logic [5:0] dt_r;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			off_r <= 3'h0;
			wipe_r <= 0;
		end else begin
			off_r <= i_logic_pwr ? 3'h0 : off_r + {2'h0, off_r != 3'h7};
			wipe_r <= i_key_pin[KEY_WIPE] ? wipe_r + 1 : 0;
		end
	end
	// pulse widths counted on the link side, where they are defined
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_r <= 6'h00;
			dt_r <= 6'h00;
		end else begin
			sh_r <= o_link_shift ? sh_r + 6'h01 : 6'h00;
			dt_r <= o_link_data ? dt_r + 6'h01 : 6'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	property p_dark;
		@(posedge i_ref_clk) disable iff (!i_rst_n) off_r == 3'h7 |->
			{o_addr_glow_numeric_display, o_data_glow_numeric_display, o_sign_plus, o_sign_minus} == '0;
	endproperty
	a_dark: assert property (p_dark) else $error("digits lit without power");
	property p_sign;
		@(posedge i_ref_clk) disable iff (!i_rst_n) !(o_sign_plus && o_sign_minus);
	endproperty
	a_sign: assert property (p_sign) else $error("both signs lit");
	property p_shift_w;
		@(posedge i_link_clk) disable iff (!i_rst_n) $fell(o_link_shift) |-> sh_r == 6'h19;
	endproperty
	a_shift_w: assert property (p_shift_w) else $error("shift pulse width");
	property p_data_w;
		@(posedge i_link_clk) disable iff (!i_rst_n) $fell(o_link_data) |-> dt_r == 6'h19;
	endproperty
	a_data_w: assert property (p_data_w) else $error("data pulse width");
	property p_pair;
		@(posedge i_link_clk) disable iff (!i_rst_n) $fell(o_link_data) |-> $rose(o_link_shift);
	endproperty
	a_pair: assert property (p_pair) else $error("data not followed by shift");
	property p_excl;
		@(posedge i_link_clk) disable iff (!i_rst_n) !(o_link_data && o_link_shift);
	endproperty
	a_excl: assert property (p_excl) else $error("data and shift overlap");
	property p_wipe;
		@(posedge i_ref_clk) disable iff (!i_rst_n) wipe_r == P_DEBOUNCE_CYC + 6 |->
			!o_op_error && !o_commit_lvl && !o_readout_lvl && o_addr_glow_numeric_display == '0;
	endproperty
	a_wipe: assert property (p_wipe) else $error("wipe left state behind");
	property p_err_held;
		@(posedge i_ref_clk) disable iff (!i_rst_n) $fell(o_op_error) |-> wipe_r > P_DEBOUNCE_CYC;
	endproperty
	a_err_held: assert property (p_err_held) else $error("error cleared without wipe");
	c_err: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_op_error));
	c_commit: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_commit_lvl));
	c_shift: cover property (@(posedge i_link_clk) disable iff (!i_rst_n) $fell(o_link_shift));
endmodule : kdt_transfer_unit_chk

bind kdt_transfer_unit kdt_transfer_unit_chk #(.P_DEBOUNCE_CYC(P_DEBOUNCE_CYC)) kdt_transfer_unit_chk_i (
	.i_ref_clk, .i_rst_n, .i_link_clk, .i_key_pin, .i_logic_pwr, .o_link_data, .o_link_shift, .o_commit_lvl,
	.o_readout_lvl, .o_op_error, .o_sign_plus, .o_sign_minus, .o_addr_glow_numeric_display,
	.o_data_glow_numeric_display);

// file: kdt_computer_model.sv
/* Behavioural guidance computer at the far end of the link.
   Runs the link clock only for its first 700 ns and during its own transfers. */
module kdt_computer_model (
	input wire logic i_link_data,
	input wire logic i_link_shift,
	output logic o_link_clk,
	output logic o_upload_req,
	output logic o_download_req,
	output logic o_link_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run = 1'b1;
	logic seen = 1'b0;
	logic prev_sh = 1'b0;
	logic [3:0] nib = 4'h0;
	logic [3:0] tx = 4'h0;
	int n_sh = 0;
	initial begin
		o_upload_req = 1'b0;
		o_download_req = 1'b0;
		o_link_data = 1'b0;
		o_link_clk = 1'b0;
		#2;
		forever begin
			o_link_clk = run ? ~o_link_clk : 1'b0;
			#40;
		end
	end
	initial #700 run = 1'b0;
	// shift edge seen one link cycle late, so data is settled before the device samples
	always @(posedge o_link_clk) begin
		prev_sh <= i_link_shift;
		if (i_link_data)
			seen <= 1'b1;
		if (i_link_shift && !prev_sh) begin
			nib <= {nib[2:0], seen};
			seen <= 1'b0;
			n_sh <= n_sh + 1;
			tx <= {tx[2:0], 1'b0};
			o_link_data <= tx[3];
			o_upload_req <= 1'b0;
			o_download_req <= 1'b0;
		end
		// line inverted after the shift: no stale value
		if (!i_link_shift && prev_sh)
			o_link_data <= ~o_link_data;
	end
	task automatic xfer(input logic up, input logic [3:0] v, output logic [3:0] got, output logic ok);
		run = 1'b1;
		@(posedge o_link_clk);
		#1;
		n_sh = 0;
		tx = v;
		o_upload_req = up;
		o_download_req = !up;
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			@(posedge o_link_clk);
			#1;
			ok = n_sh == 4 && !prev_sh;
		end
		got = nib;
		repeat (2) @(posedge o_link_clk);
		run = 1'b0;
	endtask : xfer
endmodule : kdt_computer_model

// file: kdt_transfer_unit_bench.sv
/* Self-checking bench of the transfer unit against the computer model.
   Assumes a debounce count shortened to 4 cycles. */
module kdt_transfer_unit_bench
	import kdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [35:0] W1 = 36'h123A45678;
	localparam logic [35:0] W2 = 36'h123B98765;
	localparam logic [35:0] W3 = 36'h456AF0F12;
	logic ref_clk, rst_n, pwr, lk_clk, up_req, dn_req, to_dev, from_dev, shift, cm, ro, fz, err, plus, minus;
	logic [KEY_N-1:0] key_pin;
	logic [3:0] key_code;
	logic [ADDR_DIGITS-1:0][SEG_W-1:0] a_seg;
	logic [DATA_DIGITS-1:0][SEG_W-1:0] d_seg;
	int errors = 0;
	int compares = 0;
	kdt_transfer_unit #(.P_DEBOUNCE_CYC(4)) kdt_transfer_unit_i (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_link_clk(lk_clk), .i_key_pin(key_pin), .i_key_code(key_code), .i_logic_pwr(pwr), .i_upload_req(up_req),
		.i_download_req(dn_req), .i_link_data(to_dev), .o_link_data(from_dev), .o_link_shift(shift),
		.o_commit_lvl(cm), .o_readout_lvl(ro), .o_freeze_lvl(fz), .o_op_error(err), .o_sign_plus(plus),
		.o_sign_minus(minus), .o_addr_glow_numeric_display(a_seg), .o_data_glow_numeric_display(d_seg));
	kdt_computer_model kdt_computer_model_i (.i_link_data(from_dev), .i_link_shift(shift), .o_link_clk(lk_clk),
		.o_upload_req(up_req), .o_download_req(dn_req), .o_link_data(to_dev));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", what, e, g);
		end
	endtask : chk
	function automatic logic [SEG_W-1:0] seg(input logic [3:0] c);
		return (c <= 4'h9) ? SEG_TABLE[c] : SEG_DARK;
	endfunction : seg
	task automatic show(input logic [35:0] w);
		if (!pwr)
			w = REG_BLANK;
		for (int i = 0; i < DATA_DIGITS; i++) begin
			if (i < ADDR_DIGITS)
				chk("address digit", seg(w[35-4*i -: 4]), a_seg[i]);
			chk("data digit", seg(w[19-4*i -: 4]), d_seg[i]);
		end
		chk("sign", {w[23:20] == CODE_PLUS, w[23:20] == CODE_MINUS}, {plus, minus});
	endtask : show
	task automatic key(input int k, input logic [3:0] c);
		@(posedge ref_clk);
		key_code <= c;
		key_pin[k] <= 1'b1;
		repeat (12) @(posedge ref_clk);
		key_pin[k] <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask : key
	task automatic entry(input logic [35:0] w, input int n);
		key(KEY_WIPE, 4'h0);
		for (int i = 0; i < n; i++)
			key(KEY_DIGIT, w[35-4*i -: 4]);
	endtask : entry
	task automatic link(input logic up, input logic [3:0] v, input logic [3:0] e);
		logic [3:0] got;
		logic ok;
		kdt_computer_model_i.xfer(up, v, got, ok);
		chk("transfer done", 1'b1, ok);
		if (!ok)
			end_sim();
		if (up)
			chk("upload nibble", e, got);
	endtask : link
	task automatic fetch(input logic [35:0] w);
		for (int i = 0; i < DIGITS; i++)
			link(1'b0, w[35-4*i -: 4], 4'h0);
		repeat (8) @(posedge ref_clk);
		show(w);
	endtask : fetch
	////////////////////////////////////////////////////////////////////////////
	task automatic t_entry();
		key(KEY_DIGIT, 4'h5);
		show(REG_BLANK);
		entry(W1, 1);
		show({4'h1, 32'hFFFFFFFF});
		for (int i = 1; i < DIGITS; i++)
			key(KEY_DIGIT, W1[35-4*i -: 4]);
		show(W1);
		pwr <= 1'b0;
		repeat (8) @(posedge ref_clk);
		show(W1);
		pwr <= 1'b1;
		repeat (8) @(posedge ref_clk);
		$display("entry test done");
	endtask : t_entry
	task automatic t_upload();
		key(KEY_COMMIT, 4'h0);
		chk("commit", 1'b1, cm);
		chk("error", 1'b0, err);
		for (int i = 0; i < DIGITS; i++) begin
			link(1'b1, 4'h0, W1[35-4*i -: 4]);
			if (i == 0)
				show({W1[31:0], 4'hF});
		end
		show(REG_BLANK);
		$display("upload test done");
	endtask : t_upload
	task automatic t_errors();
		entry(W1, 2);
		key(KEY_COMMIT, 4'h0);
		chk("error", 1'b1, err);
		link(1'b1, 4'h0, 4'hF);
		entry(W1, 2);
		chk("error", 1'b0, err);
		key(KEY_READOUT, 4'h0);
		chk("error", 1'b1, err);
		$display("error test done");
	endtask : t_errors
	task automatic t_readout();
		entry(W1, 3);
		key(KEY_READOUT, 4'h0);
		chk("readout", 1'b1, ro);
		chk("error", 1'b0, err);
		for (int i = 0; i < 3; i++)
			link(1'b1, 4'h0, W1[35-4*i -: 4]);
		fetch(W2);
		key(KEY_FREEZE, 4'h0);
		chk("freeze", 1'b1, fz);
		fetch(W3);
		key(KEY_READOUT, 4'h0);
		chk("freeze", 1'b0, fz);
		fetch(W2);
		key(KEY_WIPE, 4'h0);
		show(REG_BLANK);
		chk("readout", 1'b0, ro);
		$display("readout test done");
	endtask : t_readout
	initial begin
		rst_n = 1'b0;
		pwr = 1'b1;
		key_pin = '0;
		key_code = 4'h0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_entry();
		t_upload();
		t_errors();
		t_readout();
		end_sim();
	end
endmodule : kdt_transfer_unit_bench
